// [rtl/hpra_regs.svh]
// register codes, field positions and timing counts of the host port
`ifndef HPRA_REGS_SVH
`define HPRA_REGS_SVH
// ----------------------------------------------------------------------
// register select codes
// ----------------------------------------------------------------------
`define HPRA_SEL_DATA 4'h2
`define HPRA_SEL_SCRATCH 4'h3
`define HPRA_SEL_OWN_ADDR 4'h4
`define HPRA_SEL_PEER_ADDR 4'h8
`define HPRA_SEL_WINDOW 4'hF
// ----------------------------------------------------------------------
// indirect window fields
// ----------------------------------------------------------------------
`define HPRA_WIN_RD_BIT 31
`define HPRA_WIN_AMU_BIT 30
`define HPRA_WIN_TYPE_HI 27
`define HPRA_WIN_TYPE_LO 24
`define HPRA_WIN_DATA_HI 23
`define HPRA_WIN_DATA_LO 16
`define HPRA_WIN_IDX_HI 10
`define HPRA_WIN_IDX_LO 8
`define HPRA_WIN_AMU_HI 7
`define HPRA_WIN_AMU_LO 0
`define HPRA_IES_TYPE 4'hF
`define HPRA_IES_INDEX 3'h0
// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define HPRA_RST_WORD 32'h0000_0000
`define HPRA_RST_COUNT 16'h0000
`define HPRA_STEP32 16'h0004
`define HPRA_STEP64 16'h0008
`define HPRA_SYNC_CYCLES 2'h2
`endif

// [rtl/hpra_pkg.sv]
// types shared by the host port register access block
package hpra_pkg;
   // ----------------------------------------------------------------------
   // port activity as set by the core
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      HPRA_IDLE,
      HPRA_RING_RD,
      HPRA_RING_WR,
      HPRA_DATA_TX,
      HPRA_DATA_RX
   } hpra_kind_t;

   typedef enum logic [1:0] {
      HPRA_WIN_FREE,
      HPRA_WIN_SYNC,
      HPRA_WIN_WAIT
   } hpra_win_t;

   // context load and access report from the port control unit
   typedef struct packed {
      logic load;
      hpra_kind_t kind;
      logic [31:0] addr;
      logic [31:0] ring_max_length;
      logic [15:0] count;
      logic local_mem;
      logic acc_done;
      logic acc_not_owned;
      logic acc_err;
      logic acc_marker_err;
   } hpra_core_t;

   // request to the internal 8-bit control registers
   typedef struct packed {
      logic req;
      logic rd;
      logic amu;
      logic [3:0] rtype;
      logic [2:0] index;
      logic [7:0] amu_addr;
      logic [7:0] wdata;
   } hpra_ireq_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] ring_base;
      logic [31:0] ring_end;
      logic [15:0] count;
      hpra_kind_t kind;
      logic local_mem;
      logic [31:0] scratch;
      logic [31:0] win;
      logic free;
      hpra_win_t wst;
      logic [1:0] wcnt;
      logic ireq;
      logic [31:0] rdata;
      logic [31:0] tx_word;
      logic tx_valid;
      logic rx_taken;
   } hpra_state_t;
endpackage

// [rtl/hpra_port.sv]
// one system port: transfer counter, address generator and host registers
// Operation
// [R1] transmit data read: counter holds bytes left in current buffer
// [R2] receive data write: counter holds bytes of frame left to write
// [R3] ring read: counter shows bytes expected; meaningless on ring write
// [R4] port may switch activity before counter reaches zero
// [R5] code 0100 returns this port's address generator value
// [R6] ring access: start at ring address, increment, wrap at max length
// [R7] data access: start at buffer address, wrap at local memory boundary
// [R8] reads leave address alone; data access advances it by 4 or 8
// [R9] ring read not owned by core does not advance address
// [R10] ring read parity/port error keeps address on failing descriptor
// [R11] first/last marker error leaves address generator unchanged
// [R12] host ignores address value while port request lines are idle
// [R13] code 1000 returns the other port's address generator
// [R14] in read state host only writes data register at 0010
// [R15] in write state host only reads data register
// [R16] 64-bit mode: A holds upper half, address from port A
// [R17] scratch at 0011 is host read/write, never touched by device
// [R18] host writes window at 1111 only while free flag is set
// [R19] window write, bit 31 clear: data 23-16 goes to selected register
// [R20] window read: device fills data field then sets free flag
// [R21] internal error status sits at type F index 0
// [R22] same window carries address match unit accesses
// [R23] free flag clears on window write until internal transfer ends
`timescale 1ns/100ps
`include "hpra_regs.svh"
module hpra_port #(
   parameter int LOCAL_AW = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic is_port_a,
   input wire logic mode_64,
   input wire logic [3:0] register_select_lines,
   input wire logic host_rd,
   input wire logic host_wr,
   input wire logic [31:0] host_wdata,
   output logic [31:0] host_rdata,
   input wire hpra_pkg::hpra_core_t core_in,
   input wire logic [31:0] core_rx_word,
   output logic rx_word_taken,
   output logic [31:0] tx_word,
   output logic tx_word_valid,
   input wire logic [31:0] peer_address,
   output logic [31:0] port_address_register,
   output logic [15:0] transfer_counter,
   output logic control_register_free,
   output hpra_pkg::hpra_ireq_t ireq,
   input wire logic iack,
   input wire logic [7:0] irdata
);
   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   hpra_pkg::hpra_state_t st_r;
   hpra_pkg::hpra_state_t st_nxt;

   logic rd_state;
   logic wr_state;
   logic [15:0] step;
   logic [31:0] sum;
   logic [31:0] adv_addr;
   logic core_adv;
   logic host_adv;
   logic win_wr;

   assign rd_state = (st_r.kind == hpra_pkg::HPRA_RING_RD) ||
                     (st_r.kind == hpra_pkg::HPRA_DATA_TX);
   assign wr_state = (st_r.kind == hpra_pkg::HPRA_RING_WR) ||
                     (st_r.kind == hpra_pkg::HPRA_DATA_RX);
   assign step = mode_64 ? `HPRA_STEP64 : `HPRA_STEP32; // [R8]
   assign sum = st_r.addr + {16'h0000, step};
   assign win_wr = host_wr && (register_select_lines == `HPRA_SEL_WINDOW);

   // ----------------------------------------------------------------------
   // next address
   // ----------------------------------------------------------------------
   always_comb begin
      adv_addr = sum;
      if ((st_r.kind == hpra_pkg::HPRA_RING_RD) ||
          (st_r.kind == hpra_pkg::HPRA_RING_WR)) begin
         if (sum >= st_r.ring_end) begin
            adv_addr = st_r.ring_base; // [R6]
         end
      end else if (st_r.local_mem) begin
         // carry stops at the local space edge
         adv_addr = {st_r.addr[31:LOCAL_AW], sum[LOCAL_AW-1:0]}; // [R7]
      end
   end

   // a core access counts only when it really completed
   always_comb begin
      core_adv = core_in.acc_done && !core_in.acc_marker_err; // [R11]
      if (st_r.kind == hpra_pkg::HPRA_RING_RD) begin
         if (core_in.acc_not_owned) begin
            core_adv = 1'b0; // [R9]
         end
         if (core_in.acc_err) begin
            core_adv = 1'b0; // [R10]
         end
      end
   end

   // data register accesses in the allowed direction only
   assign host_adv = (register_select_lines == `HPRA_SEL_DATA) &&
                     ((host_wr && rd_state) || (host_rd && wr_state));

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.tx_valid = 1'b0;
      st_nxt.rx_taken = 1'b0;
      st_nxt.ireq = 1'b0;

      // address generator and counter; of the host reads only a data register read moves it
      if (core_in.load) begin
         // a reload may come at any count: context switch
         st_nxt.kind = core_in.kind; // [R4]
         st_nxt.addr = core_in.addr; // [R6] [R7]
         st_nxt.ring_base = core_in.addr;
         st_nxt.ring_end = core_in.addr + core_in.ring_max_length;
         st_nxt.count = core_in.count; // [R1] [R2] [R3]
         st_nxt.local_mem = core_in.local_mem;
      end else if (core_adv || host_adv) begin
         st_nxt.addr = adv_addr; // [R8]
         if (st_r.kind != hpra_pkg::HPRA_RING_WR) begin
            if (st_r.count > step) begin
               st_nxt.count = st_r.count - step; // [R1] [R2] [R3]
            end else begin
               st_nxt.count = `HPRA_RST_COUNT;
            end
         end
      end

      // data register
      if (host_adv && host_wr) begin
         st_nxt.tx_word = host_wdata; // [R14]
         st_nxt.tx_valid = 1'b1;
      end
      if (host_adv && host_rd) begin
         st_nxt.rx_taken = 1'b1; // [R15]
      end

      // scratch: host only
      if (host_wr && (register_select_lines == `HPRA_SEL_SCRATCH)) begin
         st_nxt.scratch = host_wdata; // [R17]
      end

      // indirect window
      case (st_r.wst)
         hpra_pkg::HPRA_WIN_FREE: begin
            // writes while busy are dropped, host must poll free first
            if (win_wr && st_r.free) begin // [R18]
               st_nxt.win = host_wdata;
               st_nxt.free = 1'b0; // [R23]
               st_nxt.wcnt = `HPRA_SYNC_CYCLES;
               st_nxt.wst = hpra_pkg::HPRA_WIN_SYNC;
            end
         end
         hpra_pkg::HPRA_WIN_SYNC: begin
            // hold-off that stands for the core clock crossing
            if (st_r.wcnt == 2'h1) begin
               st_nxt.ireq = 1'b1; // [R19]
               st_nxt.wst = hpra_pkg::HPRA_WIN_WAIT;
            end
            st_nxt.wcnt = st_r.wcnt - 2'h1;
         end
         hpra_pkg::HPRA_WIN_WAIT: begin
            if (iack) begin
               if (st_r.win[`HPRA_WIN_RD_BIT]) begin
                  st_nxt.win[`HPRA_WIN_DATA_HI:`HPRA_WIN_DATA_LO] =
                     irdata; // [R20]
               end
               st_nxt.free = 1'b1; // [R19] [R20] [R23]
               st_nxt.wst = hpra_pkg::HPRA_WIN_FREE;
            end else begin
               // keep asking until the register bank answers
               st_nxt.ireq = 1'b1;
            end
         end
         default: begin
            st_nxt.wst = hpra_pkg::HPRA_WIN_FREE;
            st_nxt.free = 1'b1;
         end
      endcase

      // read data, registered one cycle after the strobe
      st_nxt.rdata = `HPRA_RST_WORD;
      if (host_rd) begin
         case (register_select_lines)
            `HPRA_SEL_DATA: begin
               if (wr_state) begin
                  st_nxt.rdata = core_rx_word; // [R15] [R16]
               end
            end
            `HPRA_SEL_SCRATCH: begin
               st_nxt.rdata = st_r.scratch; // [R17]
            end
            `HPRA_SEL_OWN_ADDR: begin
               // in 64-bit mode port A owns the generator
               if (mode_64 && !is_port_a) begin
                  st_nxt.rdata = peer_address; // [R16]
               end else begin
                  st_nxt.rdata = st_r.addr; // [R5]
               end
            end
            `HPRA_SEL_PEER_ADDR: begin
               st_nxt.rdata = peer_address; // [R13]
            end
            `HPRA_SEL_WINDOW: begin
               st_nxt.rdata = st_r.win; // [R20]
            end
            default: begin
               st_nxt.rdata = `HPRA_RST_WORD;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         st_r <= '0;
         st_r.kind <= hpra_pkg::HPRA_IDLE;
         st_r.wst <= hpra_pkg::HPRA_WIN_FREE;
         st_r.free <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign host_rdata = st_r.rdata;
   assign tx_word = st_r.tx_word;
   assign tx_word_valid = st_r.tx_valid;
   assign rx_word_taken = st_r.rx_taken;
   // value only meaningful while the port is not idle
   assign port_address_register = st_r.addr; // [R12]
   assign transfer_counter = st_r.count;
   assign control_register_free = st_r.free;
   assign ireq.req = st_r.ireq;
   assign ireq.rd = st_r.win[`HPRA_WIN_RD_BIT];
   assign ireq.amu = st_r.win[`HPRA_WIN_AMU_BIT]; // [R22]
   // type F index 0 reaches the internal error status register
   assign ireq.rtype = st_r.win[`HPRA_WIN_TYPE_HI:`HPRA_WIN_TYPE_LO]; // [R21]
   assign ireq.index = st_r.win[`HPRA_WIN_IDX_HI:`HPRA_WIN_IDX_LO]; // [R21]
   assign ireq.amu_addr = st_r.win[`HPRA_WIN_AMU_HI:`HPRA_WIN_AMU_LO];
   assign ireq.wdata = st_r.win[`HPRA_WIN_DATA_HI:`HPRA_WIN_DATA_LO]; // [R19]
endmodule

// [verif/hpra_port_monitor.sv]
// checker for the host port register access block
`timescale 1ns/100ps
`include "hpra_regs.svh"
module hpra_port_monitor #(
   parameter int LOCAL_AW = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic is_port_a,
   input wire logic mode_64,
   input wire logic [3:0] register_select_lines,
   input wire logic host_rd,
   input wire logic host_wr,
   input wire logic [31:0] host_wdata,
   input wire logic [31:0] host_rdata,
   input wire hpra_pkg::hpra_core_t core_in,
   input wire logic rx_word_taken,
   input wire logic [31:0] tx_word,
   input wire logic tx_word_valid,
   input wire logic [31:0] peer_address,
   input wire logic [31:0] port_address_register,
   input wire logic control_register_free,
   input wire hpra_pkg::hpra_ireq_t ireq,
   input wire logic iack
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   wire logic [3:0] sel = register_select_lines;
   wire logic win_wr = host_wr && sel == `HPRA_SEL_WINDOW
      && control_register_free;
   wire logic quiet = !core_in.load && !core_in.acc_done;
   property p_free_falls;
      win_wr |=> !control_register_free;
   endproperty
   a_free_falls: assert property (p_free_falls) else $error("free kept");
   property p_req_start;
      win_wr |-> ##3 ireq.req;
   endproperty
   a_req_start: assert property (p_req_start) else $error("no request");
   property p_req_end;
      ireq.req && iack |=> !ireq.req && control_register_free;
   endproperty
   a_req_end: assert property (p_req_end) else $error("bad finish");
   property p_free_rise;
      $rose(control_register_free) |-> $past(iack);
   endproperty
   a_free_rise: assert property (p_free_rise) else $error("early free");
   property p_own_addr;
      host_rd && sel == `HPRA_SEL_OWN_ADDR |=>
         host_rdata == $past((mode_64 && !is_port_a) ? peer_address :
            port_address_register);
   endproperty
   a_own_addr: assert property (p_own_addr) else $error("own addr");
   property p_peer;
      host_rd && sel == `HPRA_SEL_PEER_ADDR |=>
         host_rdata == $past(peer_address);
   endproperty
   a_peer: assert property (p_peer) else $error("peer addr");
   property p_read_keeps;
      host_rd && sel != `HPRA_SEL_DATA && quiet |=>
         $stable(port_address_register);
   endproperty
   a_read_keeps: assert property (p_read_keeps) else $error("moved");
   property p_marker;
      core_in.acc_done && core_in.acc_marker_err && !core_in.load
         && !host_rd && !host_wr |=> $stable(port_address_register);
   endproperty
   a_marker: assert property (p_marker) else $error("marker moved");
   property p_tx_word;
      tx_word_valid |-> $past(host_wr) && $past(sel) == `HPRA_SEL_DATA
         && tx_word == $past(host_wdata);
   endproperty
   a_tx_word: assert property (p_tx_word) else $error("tx word");
   property p_rx_taken;
      rx_word_taken |-> $past(host_rd) && $past(sel) == `HPRA_SEL_DATA;
   endproperty
   a_rx_taken: assert property (p_rx_taken) else $error("rx taken");
   c_window: cover property (ireq.req && iack);
   c_tx: cover property (tx_word_valid);
   c_rx: cover property (rx_word_taken);
endmodule

// [verif/hpra_host_model.sv]
// host processor model driving the register strobes
`timescale 1ns/100ps
module hpra_host_model (
   input wire logic clk,
   output logic host_rd,
   output logic host_wr,
   output logic [3:0] sel,
   output logic [31:0] wdata,
   input wire logic [31:0] rdata
);
   initial begin
      host_rd = 1'b0;
      host_wr = 1'b0;
      sel = 4'h0;
      wdata = 32'h0000_0000;
   end
   // released data is inverted so stale values never look valid
   task automatic wr(input logic [3:0] c, input logic [31:0] d);
      @(posedge clk);
      host_wr <= 1'b1;
      sel <= c;
      wdata <= d;
      @(posedge clk);
      host_wr <= 1'b0;
      wdata <= ~d;
      #1;
   endtask
   task automatic rd(input logic [3:0] c, output logic [31:0] d);
      @(posedge clk);
      host_rd <= 1'b1;
      sel <= c;
      @(posedge clk);
      host_rd <= 1'b0;
      #1 d = rdata;
   endtask
endmodule

// [verif/test_host_port_register_access.sv]
// self-checking bench for the host port register access block
`timescale 1ns/100ps
`include "hpra_regs.svh"
module test_host_port_register_access;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic mode_64 = 1'b0;
   logic porta = 1'b1;
   logic [31:0] rx_w = 32'hC0DE_0001;
   logic [31:0] peer = 32'hA5A5_0000;
   logic iack = 1'b0;
   logic [7:0] bank = 8'h3C;
   hpra_pkg::hpra_core_t core = '0;
   int ack_dly = 0;
   int wait_n = 0;
   int cycles = 0;
   int failures = 0;
   int cmp_count = 0;
   logic rd;
   logic wr;
   logic [3:0] sel;
   logic [31:0] wd;
   logic [31:0] rdat;
   logic [31:0] adr;
   logic [31:0] txw;
   logic [31:0] v;
   logic [15:0] cnt;
   logic txv;
   logic rxt;
   logic free;
   hpra_pkg::hpra_ireq_t ireq;
   always #2.5 clk = ~clk;
   hpra_host_model host (.clk(clk), .host_rd(rd), .host_wr(wr),
      .sel(sel), .wdata(wd), .rdata(rdat));
   hpra_port #(.LOCAL_AW(16)) uut (.clk(clk), .srst(srst),
      .is_port_a(porta), .mode_64(mode_64), .register_select_lines(sel),
      .host_rd(rd), .host_wr(wr), .host_wdata(wd), .host_rdata(rdat),
      .core_in(core), .core_rx_word(rx_w), .rx_word_taken(rxt),
      .tx_word(txw), .tx_word_valid(txv), .peer_address(peer),
      .port_address_register(adr), .transfer_counter(cnt),
      .control_register_free(free), .ireq(ireq), .iack(iack),
      .irdata(bank));
   // ----
   // register bank raises iack ack_dly+1 cycles after the request rises
   // ----
   always @(posedge clk) begin
      iack <= ireq.req && !iack && wait_n == ack_dly;
      if (ireq.req && !iack) wait_n <= (wait_n == ack_dly) ? 0 : wait_n + 1;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         failures++;
         wrap_up();
      end
   end
   task automatic wrap_up;
      $display("compares %0d errors %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic load(input hpra_pkg::hpra_kind_t k,
      input logic [31:0] a, input logic [15:0] c, input logic lm);
      @(posedge clk);
      core.load <= 1'b1;
      core.kind <= k;
      core.addr <= a;
      core.count <= c;
      core.ring_max_length <= 32'h0000_0010;
      core.local_mem <= lm;
      @(posedge clk);
      core.load <= 1'b0;
      #1;
   endtask
   task automatic acc(input logic [2:0] q);
      @(posedge clk);
      core.acc_done <= 1'b1;
      {core.acc_not_owned, core.acc_err, core.acc_marker_err} <= q;
      @(posedge clk);
      core.acc_done <= 1'b0;
      #1;
   endtask
   task automatic wait_free;
      for (int i = 0; i < 30 && free !== 1'b1; i++) @(negedge clk);
      chk("free", 1, {31'h0, free});
   endtask
   task automatic wait_req;
      for (int i = 0; i < 30 && ireq.req !== 1'b1; i++) @(negedge clk);
   endtask
   task automatic t_reset;
      srst <= 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      #1;
      chk("free", 1, {31'h0, free});
      chk("adr", 0, adr);
      host.wr(`HPRA_SEL_SCRATCH, 32'h1234_ABCD);
      host.rd(`HPRA_SEL_SCRATCH, v);
      chk("scratch", 32'h1234_ABCD, v);
      host.rd(4'h0, v);
      chk("unmapped", 0, v);
   endtask
   task automatic t_ring;
      load(hpra_pkg::HPRA_RING_RD, 32'h0000_0100, 16'h0010, 1'b0);
      chk("cnt", 32'h10, {16'h0, cnt});
      host.rd(`HPRA_SEL_OWN_ADDR, v);
      chk("own", 32'h100, v);
      chk("adr", 32'h100, adr);
      acc(3'b100);
      chk("empty", 32'h100, adr);
      acc(3'b010);
      chk("err", 32'h100, adr);
      acc(3'b001);
      chk("marker", 32'h100, adr);
      for (int i = 1; i < 5; i++) begin
         acc(3'b000);
         chk("ring", (i == 4) ? 32'h100 : 32'h100 + 4 * i, adr);
      end
   endtask
   task automatic t_data;
      load(hpra_pkg::HPRA_DATA_TX, 32'h0000_2000, 16'h0008, 1'b0);
      host.wr(`HPRA_SEL_DATA, 32'hDEAD_BEEF);
      chk("txw", 32'hDEAD_BEEF, txw);
      chk("txv", 1, {31'h0, txv});
      chk("adr", 32'h2004, adr);
      chk("cnt", 4, {16'h0, cnt});
      host.rd(`HPRA_SEL_DATA, v);
      chk("wrong rd", 0, v);
      mode_64 <= 1'b1;
      host.wr(`HPRA_SEL_DATA, 32'h0F0F_0F0F);
      chk("adr64", 32'h200C, adr);
      mode_64 <= 1'b0;
      load(hpra_pkg::HPRA_DATA_RX, 32'h0000_FFFC, 16'h0008, 1'b1);
      host.rd(`HPRA_SEL_DATA, v);
      chk("rx", rx_w, v);
      chk("rxt", 1, {31'h0, rxt});
      chk("wrap", 0, adr);
      chk("cnt", 4, {16'h0, cnt});
      host.wr(`HPRA_SEL_DATA, 32'h1111_2222);
      chk("wrong wr", 0, {31'h0, txv});
      host.rd(`HPRA_SEL_PEER_ADDR, v);
      chk("peer", peer, v);
      porta <= 1'b0;
      mode_64 <= 1'b1;
      host.rd(`HPRA_SEL_OWN_ADDR, v);
      chk("port b own addr", peer, v);
      porta <= 1'b1;
      mode_64 <= 1'b0;
   endtask
   task automatic t_win;
      ack_dly = 4;
      host.wr(`HPRA_SEL_WINDOW, {8'h0F, 8'h5A, 16'h0000});
      chk("busy", 0, {31'h0, free});
      host.wr(`HPRA_SEL_WINDOW, {8'h0F, 8'hEE, 16'h0000});
      wait_req();
      chk("wdata", 32'h5A, {24'h0, ireq.wdata});
      chk("type", 32'hF, {28'h0, ireq.rtype});
      chk("rd", 0, {31'h0, ireq.rd});
      wait_free();
      ack_dly = 1;
      host.wr(`HPRA_SEL_WINDOW, {8'h81, 8'h00, 16'h0200});
      wait_free();
      host.rd(`HPRA_SEL_WINDOW, v);
      chk("window", {24'h0, bank}, {24'h0, v[23:16]});
      host.wr(`HPRA_SEL_WINDOW, 32'h4000_0047);
      wait_req();
      chk("amu", 32'h147, {23'h0, ireq.amu, ireq.amu_addr});
      wait_free();
   endtask
   initial begin
      t_reset();
      t_ring();
      t_data();
      t_win();
      t_reset();
      wrap_up();
   end
endmodule
bind hpra_port hpra_port_monitor #(.LOCAL_AW(LOCAL_AW)) mon (.clk(clk),
   .srst(srst), .is_port_a(is_port_a), .mode_64(mode_64),
   .register_select_lines(register_select_lines),
   .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata),
   .host_rdata(host_rdata), .core_in(core_in),
   .rx_word_taken(rx_word_taken), .tx_word(tx_word),
   .tx_word_valid(tx_word_valid), .peer_address(peer_address),
   .port_address_register(port_address_register),
   .control_register_free(control_register_free), .ireq(ireq),
   .iack(iack));
